// >>> hw/i2c_status_pkg.sv
package i2c_status_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] ADDR_CTL = 8'hcb;
  localparam logic [7:0] ADDR_STATUS = 8'hcc;
  localparam logic [7:0] ADDR_DIV = 8'hcc;
  localparam logic [7:0] ADDR_SRR = 8'hcd;

  localparam int CTL_IEN = 7;
  localparam int CTL_ENAB = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STP = 4;
  localparam int CTL_INTERRUPT_FLAG = 3;
  localparam int CTL_AAK = 2;
  localparam int STAT_MSB = 7;
  localparam int STAT_LSB = 3;
  localparam int DIV_M_MSB = 6;
  localparam int DIV_M_LSB = 3;
  localparam int DIV_N_MSB = 2;
  localparam int DIV_N_LSB = 0;
  localparam int DIV_M_W = 4;
  localparam int DIV_N_W = 3;

  localparam logic [2:0] STAT_LOW_ZERO = 3'h0;
  localparam logic [1:0] CTL_LOW_ZERO = 2'h0;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic [6:0] DIV_RESET = 7'h00;

  // ****************************************
  // State codes
  // ****************************************
  localparam logic [4:0] CODE_IDLE = 5'h1f;
  localparam logic [4:0] CODE_BUS_ERROR = 5'h00;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00, ST_START = 8'h08, ST_RESTART = 8'h10;
  localparam logic [7:0] ST_MT_AW_ACK = 8'h18, ST_MT_AW_NACK = 8'h20, ST_MT_D_ACK = 8'h28;
  localparam logic [7:0] ST_MT_D_NACK = 8'h30, ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_MR_AR_ACK = 8'h40, ST_MR_AR_NACK = 8'h48;
  localparam logic [7:0] ST_MR_D_ACK = 8'h50, ST_MR_D_NACK = 8'h58;
  localparam logic [7:0] ST_SR_AW = 8'h60, ST_SR_AW_ARB = 8'h68, ST_SR_D_ACK = 8'h80;
  localparam logic [7:0] ST_SR_D_NACK = 8'h88, ST_SR_STOP = 8'ha0;
  localparam logic [7:0] ST_GC_ACK = 8'h70, ST_GC_ARB = 8'h78, ST_GC_D_ACK = 8'h90;
  localparam logic [7:0] ST_GC_D_NACK = 8'h98;
  localparam logic [7:0] ST_ST_AR = 8'ha8, ST_ST_AR_ARB = 8'hb0, ST_ST_D_ACK = 8'hb8;
  localparam logic [7:0] ST_ST_D_NACK = 8'hc0, ST_ST_LAST = 8'hc8;
  localparam logic [7:0] ST_M10_ACK = 8'hd0, ST_M10_NACK = 8'hd8;

  // ****************************************
  // Clock generation
  // ****************************************
  localparam int SCL_HALF_SAMPLES = 5;

  typedef enum logic [1:0] {
    RS_NORMAL = 2'b01,
    RS_ERROR = 2'b10
  } run_state_t;

  function automatic logic is_defined_code(input logic [7:0] code);
    case (code)
      ST_BUS_ERROR, ST_START, ST_RESTART, ST_MT_AW_ACK, ST_MT_AW_NACK, ST_MT_D_ACK,
      ST_MT_D_NACK, ST_ARB_LOST, ST_MR_AR_ACK, ST_MR_AR_NACK, ST_MR_D_ACK, ST_MR_D_NACK,
      ST_SR_AW, ST_SR_AW_ARB, ST_SR_D_ACK, ST_SR_D_NACK, ST_SR_STOP, ST_GC_ACK, ST_GC_ARB,
      ST_GC_D_ACK, ST_GC_D_NACK, ST_ST_AR, ST_ST_AR_ARB, ST_ST_D_ACK, ST_ST_D_NACK,
      ST_ST_LAST, ST_M10_ACK, ST_M10_NACK: is_defined_code = 1'b1;
      default: is_defined_code = 1'b0;
    endcase
  endfunction

endpackage

// >>> hw/divider_if.sv
`timescale 1ns/1ns
`default_nettype none
interface divider_if #(parameter int SCALAR_W = 4, parameter int EXP_W = 3);
  logic ce;
  logic srst;
  logic [SCALAR_W-1:0] scalar;
  logic [EXP_W-1:0] exponent;
  logic run;
  logic sample_tick;
  logic scl_high;

  modport top (output ce, srst, scalar, exponent, run, input sample_tick, scl_high);
  modport pre (input ce, srst, exponent, output sample_tick);
  modport brs (input ce, srst, scalar, run, sample_tick, output scl_high);
endinterface
`default_nettype wire

// >>> hw/sample_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module sample_prescaler #(parameter int EXP_W = 3)
(
  input wire logic i_ref_clk,
  divider_if.pre dif
);
  localparam int CNT_W = (2 ** EXP_W) - 1;

  generate
    if (EXP_W < 1 || EXP_W > 4)
    begin : g_bad_exp
      $error("sample_prescaler: EXP_W must lie in 1..4");
    end
  endgenerate

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  // At the largest exponent the shift wraps to zero and the minus one gives all ones
  assign limit = CNT_W'((CNT_W'(1) << dif.exponent) - CNT_W'(1));

  always_ff @(posedge i_ref_clk)
  begin
    if (dif.srst)
    begin
      cnt <= '0;
      dif.sample_tick <= 1'b0;
    end
    else if (dif.ce)
    begin
      if (cnt >= limit)
      begin
        cnt <= '0;
        dif.sample_tick <= 1'b1;
      end
      else
      begin
        cnt <= CNT_W'(cnt + CNT_W'(1));
        dif.sample_tick <= 1'b0;
      end
    end
  end
endmodule // sample_prescaler
`default_nettype wire

// >>> hw/bit_rate_stage.sv
`timescale 1ns/1ns
`default_nettype none
module bit_rate_stage
  import i2c_status_pkg::*;
#(parameter int SCALAR_W = 4)
(
  input wire logic i_ref_clk,
  divider_if.brs dif
);
  localparam int CNT_W = $clog2(SCL_HALF_SAMPLES * (2 ** SCALAR_W));

  generate
    if (SCALAR_W < 1 || SCALAR_W > 6)
    begin : g_bad_scalar
      $error("bit_rate_stage: SCALAR_W must lie in 1..6");
    end
  endgenerate

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] half_last;

  // Half a bus clock is five sample ticks times (M+1)
  assign half_last = CNT_W'(SCL_HALF_SAMPLES * (int'(dif.scalar) + 1) - 1);

  always_ff @(posedge i_ref_clk)
  begin
    if (dif.srst)
    begin
      cnt <= '0;
      dif.scl_high <= 1'b1;
    end
    else if (dif.ce)
    begin
      if (!dif.run)
      begin
        cnt <= '0;
        dif.scl_high <= 1'b1;
      end
      else if (dif.sample_tick)
      begin
        // A smaller scalar written mid-half must not let the count run past its end
        if (cnt >= half_last)
        begin
          cnt <= '0;
          dif.scl_high <= !dif.scl_high;
        end
        else
        begin
          cnt <= CNT_W'(cnt + CNT_W'(1));
        end
      end
    end
  end
endmodule // bit_rate_stage
`default_nettype wire

// >>> hw/i2c_status_and_clock_divider.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - State register holds 5-bit code in bits 7..3, low three bits read zero.
// - State register reads and divider register writes share one address.
// - Idle code F8h means no state, no interrupt, flag clear.
// - Entering a defined non-idle state loads its code and sets the flag.
// - Clearing the interrupt flag returns the state register to idle.
// - Master transmit codes 08h to 38h.
// - Master receive codes 40h to 58h.
// - Slave receive codes 60h, 68h, 80h, 88h, A0h.
// - Broadcast codes 70h, 78h, 90h, 98h.
// - Slave transmit codes A8h to C8h.
// - Ten-bit master second address byte codes D0h and D8h.
// - Illegal bus condition enters bus error, code 00h.
// - Bus error left by stop request plus flag clear, no stop driven.
// - Stop and start both set in bus error: recover then send start.
// - Divider register write-only: bit 7 reserved, M in 6..3, N in 2..0.
// - Bus sampled at system clock over two to the N.
// - Master bus clock is system clock over 10 (M+1) two to the N.
// - Sampling and bit-rate dividers are separate programmable stages.
// - Any write to the soft reset register resets the whole controller.
// - Flag set holds the bus clock low and suspends transfer.
// - Stop request in master mode sends a stop and clears itself.
module i2c_status_and_clock_divider
  import i2c_status_pkg::*;
#(
  parameter int SCALAR_W = DIV_M_W,
  parameter int EXP_W = DIV_N_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output var logic [7:0] o_rdata,
  input wire logic i_state_event,
  input wire logic [7:0] i_state_code,
  input wire logic i_bus_error,
  input wire logic i_master_mode,
  output var logic o_irq,
  output var logic o_bus_enable,
  output var logic o_ack_select,
  output var logic o_start_pulse,
  output var logic o_stop_pulse,
  output var logic o_soft_reset,
  output var logic o_transfer_hold,
  output var logic o_sample_tick,
  output var logic o_scl_out,
  output var logic o_scl_oe
);

  generate
    if (SCALAR_W != DIV_M_W || EXP_W != DIV_N_W)
    begin : g_bad_fields
      $error("i2c_status_and_clock_divider: divider fields are fixed by the register layout");
    end
  endgenerate

  // ****************************************
  // Register decode
  // ****************************************
  logic srst;
  logic wr_ctl;
  logic wr_div;
  logic wr_srr;
  logic flag_clear;
  logic flag_free;
  logic take_err;
  logic take_evt;
  logic stop_fire;
  logic start_fire;
  logic stop_set;
  logic start_set;

  logic [4:0] stat;
  logic interrupt_flag;
  logic interrupt_enable;
  logic stop_request;
  logic start_request;
  logic [6:0] div;
  run_state_t run_state;

  divider_if #(.SCALAR_W(SCALAR_W), .EXP_W(EXP_W)) dif ();

  // A soft reset lands one cycle after the write so the write itself completes
  assign srst = i_rst || o_soft_reset;
  assign wr_ctl = i_wr && (i_addr == ADDR_CTL);
  assign wr_div = i_wr && (i_addr == ADDR_DIV);
  assign wr_srr = i_wr && (i_addr == ADDR_SRR);
  assign stop_set = wr_ctl && i_wdata[CTL_STP];
  assign start_set = wr_ctl && i_wdata[CTL_STA];
  // Writing one to the flag has no effect; only hardware sets it
  assign flag_clear = wr_ctl && !i_wdata[CTL_INTERRUPT_FLAG];
  assign flag_free = !interrupt_flag || flag_clear;
  assign take_err = i_bus_error && flag_free;
  assign take_evt = i_state_event && flag_free && !i_bus_error
    && is_defined_code(i_state_code)
    && (i_state_code[STAT_MSB:STAT_LSB] != CODE_IDLE);
  // Stop comes before start when both are pending
  assign stop_fire = stop_request && !interrupt_flag;
  assign start_fire = start_request && !interrupt_flag && !stop_request && (run_state == RS_NORMAL);

  // ****************************************
  // State code and interrupt flag
  // ****************************************
  // Events only land while the flag is clear or being cleared, so the code
  // cannot move under software; a clear in the same cycle as an event loses.
  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      stat <= CODE_IDLE;
      interrupt_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      if (take_err)
      begin
        stat <= CODE_BUS_ERROR;
        interrupt_flag <= 1'b1;
      end
      else if (take_evt)
      begin
        stat <= i_state_code[STAT_MSB:STAT_LSB];
        interrupt_flag <= 1'b1;
      end
      else if (flag_clear)
      begin
        stat <= CODE_IDLE;
        interrupt_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bus error recovery
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      run_state <= RS_NORMAL;
    end
    else if (i_ce)
    begin
      case (run_state)
        RS_NORMAL:
        begin
          if (take_err)
          begin
            run_state <= RS_ERROR;
          end
        end
        RS_ERROR:
        begin
          if (stop_fire && !take_err)
          begin
            run_state <= RS_NORMAL;
          end
        end
        default:
        begin
          run_state <= RS_NORMAL;
        end
      endcase
    end
  end

  // ****************************************
  // Control bits
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      interrupt_enable <= 1'b0;
      o_bus_enable <= 1'b0;
      o_ack_select <= 1'b0;
    end
    else if (i_ce && wr_ctl)
    begin
      interrupt_enable <= i_wdata[CTL_IEN];
      o_bus_enable <= i_wdata[CTL_ENAB];
      o_ack_select <= i_wdata[CTL_AAK];
    end
  end

  // A fresh write of one wins over the self clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      stop_request <= 1'b0;
      o_stop_pulse <= 1'b0;
    end
    else if (i_ce)
    begin
      o_stop_pulse <= stop_fire && i_master_mode && (run_state == RS_NORMAL);
      if (stop_set)
      begin
        stop_request <= 1'b1;
      end
      else if (stop_fire)
      begin
        stop_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      start_request <= 1'b0;
      o_start_pulse <= 1'b0;
    end
    else if (i_ce)
    begin
      o_start_pulse <= start_fire;
      if (start_set)
      begin
        start_request <= 1'b1;
      end
      else if (start_fire)
      begin
        start_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      div <= DIV_RESET;
    end
    else if (i_ce && wr_div)
    begin
      div <= i_wdata[DIV_M_MSB:DIV_N_LSB];
    end
  end

  // Reset only by the pin so the pulse cannot cancel itself
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_soft_reset <= 1'b0;
    end
    else if (i_ce)
    begin
      o_soft_reset <= wr_srr;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      o_rdata <= RDATA_NONE;
    end
    else if (i_ce)
    begin
      if (i_rd && (i_addr == ADDR_STATUS))
      begin
        o_rdata <= {stat, STAT_LOW_ZERO};
      end
      else if (i_rd && (i_addr == ADDR_CTL))
      begin
        o_rdata <= {interrupt_enable, o_bus_enable, start_request, stop_request, interrupt_flag, o_ack_select,
          CTL_LOW_ZERO};
      end
      else
      begin
        o_rdata <= RDATA_NONE;
      end
    end
  end

  // ****************************************
  // Clock dividers and bus clock pin
  // ****************************************
  assign dif.ce = i_ce;
  assign dif.srst = srst;
  assign dif.scalar = div[DIV_M_MSB:DIV_M_LSB];
  assign dif.exponent = div[DIV_N_MSB:DIV_N_LSB];
  // The bit-rate stage stops while the flag stretches the low period
  assign dif.run = i_master_mode && o_bus_enable && !interrupt_flag;

  sample_prescaler #(.EXP_W(EXP_W)) u_prescaler (
    .i_ref_clk(i_ref_clk),
    .dif(dif.pre)
  );

  bit_rate_stage #(.SCALAR_W(SCALAR_W)) u_bit_rate (
    .i_ref_clk(i_ref_clk),
    .dif(dif.brs)
  );

  always_ff @(posedge i_ref_clk)
  begin
    if (srst)
    begin
      o_irq <= 1'b0;
      o_transfer_hold <= 1'b0;
      o_sample_tick <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_irq <= interrupt_flag && interrupt_enable;
      o_transfer_hold <= interrupt_flag;
      o_sample_tick <= dif.sample_tick;
      o_scl_out <= 1'b0;
      o_scl_oe <= interrupt_flag || (dif.run && !dif.scl_high);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  idle_means_clear_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (stat == CODE_IDLE) == !interrupt_flag)
    else $error("idle code and interrupt flag disagree");

  event_loads_code_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && take_evt && !o_soft_reset)
      |=> (interrupt_flag && stat == $past(i_state_code[STAT_MSB:STAT_LSB])))
    else $error("accepted state event did not load code and flag");

  clear_gives_idle_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && flag_clear && !i_state_event && !i_bus_error) |=> (stat == CODE_IDLE && !interrupt_flag))
    else $error("flag clear did not return idle code");

  bus_error_code_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_bus_error && !interrupt_flag && !o_soft_reset)
      |=> (stat == CODE_BUS_ERROR && interrupt_flag && run_state == RS_ERROR))
    else $error("bus error not reported as code zero");

  error_exit_quiet_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && run_state == RS_ERROR && stop_fire && !stop_set && !take_err && !o_soft_reset)
      |=> (!o_stop_pulse && !stop_request && run_state == RS_NORMAL))
    else $error("bus error exit drove a stop or kept the request");

  code_held_stable_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (interrupt_flag && !flag_clear && !o_soft_reset) |=> (stat == $past(stat)))
    else $error("state code moved while flag set");

  clock_held_low_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && interrupt_flag && !o_soft_reset) |=> (o_scl_oe && !o_scl_out && o_transfer_hold))
    else $error("bus clock not held low while flag set");

  stop_self_clear_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && stop_fire && i_master_mode && run_state == RS_NORMAL && !stop_set
        && !o_soft_reset)
      |=> (o_stop_pulse && !stop_request))
    else $error("master stop request not sent or not cleared");

  status_read_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_rd && i_addr == ADDR_STATUS && !o_soft_reset)
      |=> (o_rdata == {$past(stat), STAT_LOW_ZERO}))
    else $error("state register read returned wrong value");

  soft_reset_a:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && wr_srr) |=> o_soft_reset ##1 (stat == CODE_IDLE && div == DIV_RESET && !interrupt_flag))
    else $error("soft reset write did not reset the controller");

endmodule // i2c_status_and_clock_divider
`default_nettype wire

// >>> sim/bus_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module bus_engine_model
(
  input wire logic i_ref_clk,
  input wire logic i_fire,
  input wire logic i_err,
  input wire logic [7:0] i_code,
  input wire logic i_scl_oe,
  output logic o_state_event,
  output logic o_bus_error,
  output logic [7:0] o_state_code,
  output logic o_scl_line
);
  // ****************************************
  // Byte engine and far-side bus
  // ****************************************
  initial
  begin
    o_state_event = 1'b0;
    o_bus_error = 1'b0;
    o_state_code = 8'h55;
  end

  // One-cycle report; between reports the code inverts every cycle, so a stale value matches only every second cycle
  always @(posedge i_ref_clk)
  begin
    o_state_event <= i_fire & ~i_err;
    o_bus_error <= i_fire & i_err;
    o_state_code <= i_fire ? i_code : ~o_state_code;
  end

  // Pull-up on the bus clock wire
  assign o_scl_line = i_scl_oe ? 1'b0 : 1'b1;
endmodule // bus_engine_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import i2c_status_pkg::*;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_master_mode = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, code, fcode = 8'h00;
  logic fire = 1'b0, ferr = 1'b0, ev, berr, o_irq, o_start_pulse, o_stop_pulse;
  logic o_soft_reset, o_transfer_hold, o_sample_tick, o_scl_oe, scl_line, prev_oe;
  logic o_bus_enable, o_ack_select, o_scl_out;
  int fail_count = 0, n_tests = 0, cycles = 0, n_start = 0, n_stop = 0, ticks, rises;

  always #5 i_ref_clk = ~i_ref_clk;

  i2c_status_and_clock_divider i2c_status_and_clock_divider_i (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_state_event(ev), .i_state_code(code),
    .i_bus_error(berr), .i_master_mode(i_master_mode), .o_irq(o_irq),
    .o_bus_enable(o_bus_enable), .o_ack_select(o_ack_select),
    .o_start_pulse(o_start_pulse), .o_stop_pulse(o_stop_pulse),
    .o_soft_reset(o_soft_reset), .o_transfer_hold(o_transfer_hold),
    .o_sample_tick(o_sample_tick), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe));

  bus_engine_model bus_engine_model_i (.i_ref_clk(i_ref_clk), .i_fire(fire), .i_err(ferr),
    .i_code(fcode), .i_scl_oe(o_scl_oe), .o_state_event(ev), .o_bus_error(berr),
    .o_state_code(code), .o_scl_line(scl_line));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    check(what, o_rdata, exp);
  endtask

  task automatic report(input logic err, input logic [7:0] c);
    @(posedge i_ref_clk);
    fire <= 1'b1;
    ferr <= err;
    fcode <= c;
    @(posedge i_ref_clk);
    fire <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask

  task automatic watch(input int n);
    ticks = 0;
    rises = 0;
    prev_oe = scl_line;
    // A rise is the bus clock wire going from low to high between two samples
    repeat (n)
    begin
      @(posedge i_ref_clk);
      #1;
      ticks += int'(o_sample_tick);
      rises += int'(~prev_oe & scl_line);
      prev_oe = scl_line;
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    n_start <= n_start + int'(o_start_pulse === 1'b1);
    n_stop <= n_stop + int'(o_stop_pulse === 1'b1);
    if (cycles == 10000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  logic [15:0] rows [0:29];
  initial
  begin
    // Rows: code reported, expected read-back; e0 and e8 are not defined states
    for (int k = 0; k < 30; k++)
      rows[k] = {8'(k * 8), k < 28 ? 8'(k * 8) : 8'hf8};
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(8'hcc, 8'hf8, "status after reset");
    rd(8'hcb, 8'h00, "control after reset");
    rd(8'h10, 8'h00, "unmapped read");
    $display("Reset test done");
    wr(8'hcb, 8'h80);
    for (int k = 0; k < 30; k++)
    begin
      report(1'b0, rows[k][15:8]);
      rd(8'hcc, rows[k][7:0], "state code");
      check("irq", {7'h0, o_irq}, {7'h0, rows[k][7:0] != 8'hf8});
      check("hold", {7'h0, o_transfer_hold & o_scl_oe & ~o_scl_out},
        {7'h0, rows[k][7:0] != 8'hf8});
      wr(8'hcb, 8'h80);
      rd(8'hcc, 8'hf8, "code after clear");
      check("irq off", {7'h0, o_irq | scl_line === 1'b0}, 8'h00);
    end
    $display("State code table done");
    report(1'b0, 8'h28);
    report(1'b0, 8'h30);
    rd(8'hcc, 8'h28, "held code");
    wr(8'hcb, 8'hc0);
    report(1'b1, 8'h00);
    rd(8'hcc, 8'h00, "bus error code");
    // Master mode, so a stop pulse on leaving the error state would show
    i_master_mode <= 1'b1;
    wr(8'hcb, 8'hf0);
    repeat (6) @(posedge i_ref_clk);
    check("stop pulses", 8'(n_stop), 8'h00);
    check("start pulses", 8'(n_start), 8'h01);
    rd(8'hcc, 8'hf8, "code after recovery");
    wr(8'hcb, 8'hd4);
    repeat (4) @(posedge i_ref_clk);
    check("master stop", 8'(n_stop), 8'h01);
    rd(8'hcb, 8'hc4, "stop bit cleared");
    $display("Recovery test done");
    // Sampling stays at or above 1 MHz for every setting used here
    wr(8'hcc, 8'h81);
    watch(30);
    watch(200);
    check("ticks N1", 8'(ticks), 8'd100);
    check("scl M0 N1", 8'(rises), 8'd10);
    wr(8'hcc, 8'h08);
    watch(30);
    watch(200);
    check("ticks N0", 8'(ticks), 8'd200);
    check("scl M1 N0", 8'(rises), 8'd10);
    wr(8'hcc, 8'h13);
    watch(30);
    watch(240);
    check("ticks N3", 8'(ticks), 8'd30);
    check("scl M2 N3", 8'(rises), 8'd1);
    rd(8'hcc, 8'hf8, "divider write-only");
    $display("Divider test done");
    check("pins before soft reset", {6'h0, o_bus_enable, o_ack_select}, 8'h03);
    wr(8'hcd, 8'h5a);
    #1;
    check("soft reset", {7'h0, o_soft_reset}, 8'h01);
    repeat (2) @(posedge i_ref_clk);
    rd(8'hcb, 8'h00, "control after soft reset");
    check("pins after soft reset", {6'h0, o_bus_enable, o_ack_select}, 8'h00);
    watch(64);
    check("ticks after soft reset", 8'(ticks), 8'd64);
    $display("Soft reset test done");
    complete_run();
  end
endmodule // tb
`default_nettype wire
